// [rtl/srcn_consts.vh]
// Constants of the status and rolling counter register bank.
// Included by the status bank design file only; definitions only.
`ifndef SRCN_CONSTS_VH
`define SRCN_CONSTS_VH

// Register addresses, 8-bit register space
`define SRCN_ADDR_TICK      8'h00
`define SRCN_ADDR_SUMMARY   8'h01
`define SRCN_ADDR_SUPPLY    8'h02
`define SRCN_ADDR_MEMTHERM  8'h03
`define SRCN_ADDR_LINK      8'h04

// Reset values
`define SRCN_TICK_RESET     8'h00

// Summary status bit positions
`define SRCN_SUM_DSP        7
`define SRCN_SUM_LINK       5
`define SRCN_SUM_MEMTHERM   4
`define SRCN_SUM_SUPPLY     3
`define SRCN_SUM_TEST       2
`define SRCN_SUM_RESET      1
`define SRCN_SUM_INIT       0

// Supply fault bit positions
`define SRCN_SUP_MAIN       7
`define SRCN_SUP_ANALOG     3
`define SRCN_SUP_DIGITAL    2
`define SRCN_SUP_MEMORY     1
`define SRCN_SUP_SEAL       0

// Timing: clock, prescale ratio, tick period
`define SRCN_CLK_HZ         50000000
`define SRCN_PRESCALE_DIV   1000
`define SRCN_TICK_US        100
// Cycles per rolling tick, derived from clock rate and tick period
`define SRCN_TICK_CYCLES    ((`SRCN_CLK_HZ / 1000000) * `SRCN_TICK_US)
// Clock cycles per oscillator enable, one tick per prescaler period
`define SRCN_OSC_CYCLES     (`SRCN_TICK_CYCLES / `SRCN_PRESCALE_DIV)
// Supply recovery time, microseconds, default of the recovery parameter
`define SRCN_RECOVERY_US    100
`define SRCN_RECOVERY_CYC   ((`SRCN_CLK_HZ / 1000000) * `SRCN_RECOVERY_US)
// Sensor data valid delay after reset, cycles
`define SRCN_DATA_VALID_CYC 5000

`endif

// [rtl/srcn_divider.v]
// Enable divider: one-cycle pulse every RATIO cycles of enIn.
// Assumes a single clock; enIn is a same-domain enable.
`timescale 1ns/1ps
`default_nettype none
module srcn_divider #(
  parameter integer WIDTH = 10,
  parameter integer RATIO = 1000
) (
  input  wire  clk,
  input  wire  rst_b,
  input  wire  enIn,
  output reg   enOut
);

  reg  [WIDTH-1:0] count;

  ////////////////////////////////////////////////////////////////////////
  // Count enables, pulse on the last one and restart
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {WIDTH{1'b0}};
      enOut <= 1'b0;
    end else begin
      enOut <= 1'b0;
      if (enIn) begin
        if (count == RATIO[WIDTH-1:0] - 1'b1) begin
          count <= {WIDTH{1'b0}};
          enOut <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule // srcn_divider
`default_nettype wire

// [rtl/srcn_status_bank.v]
// Housekeeping register bank: rolling counter, summary and supply status.
// Assumes a host interface engine presents reads as a one-cycle strobe
// with an 8-bit address, on clk; fault monitor inputs are asynchronous.
//
// Notes on behaviour
// - 8-bit counter via divide-by-1000 prescaler
// - Counter steps each 100 us, wraps
// - Counter readable at address zero, resets zero
// - Summary and supply registers readable, read-only, both modes
// - Bit 7 ORs three self-test flags
// - Bit 5 mirrors link status register
// - Bit 4 ORs memory/thermal latch and write-active flag
// - Bit 3 ORs supply fault flags
// - Bit 2 follows test mode state
// - Bit 1 set on reset, read clears
// - Bit 0 set on reset until data valid
// - Supply bit 7 flags main supply low
// - Supply bit 3 flags analog regulator
// - Supply bit 2 flags digital regulator
// - Supply bit 1 flags memory regulator
// - Supply bit 0 flags edge seal break
// - Shared recovery timer reloads on fault
// - Clearing follows the report-off control bit
// - Link fault set on mismatch in SPI mode only, read clears
// - Write-active flag tracks memory write
`timescale 1ns/1ps
`default_nettype none
`include "srcn_consts.vh"
module srcn_status_bank #(
  parameter integer TICK_BITS     = 8,
  parameter integer PRESCALE_BITS = 10,
  parameter integer PRESCALE_DIV  = `SRCN_PRESCALE_DIV,
  parameter integer OSC_DIV       = `SRCN_OSC_CYCLES,
  parameter integer RECOVERY_CYC  = `SRCN_RECOVERY_CYC,
  parameter integer DATA_VALID_CYC = `SRCN_DATA_VALID_CYC
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        regRead,
  input  wire        regWrite,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  output reg  [7:0]  regRdData,
  input  wire        statusSent,
  input  wire [7:0]  statusSentBits,
  input  wire        selftestUnfinished,
  input  wire        commonModeFault,
  input  wire        selftestFault,
  input  wire        linkMismatchEvent,
  input  wire        spiMode,
  input  wire        memThermalEvent,
  input  wire        memWriteActive,
  input  wire        testEnter,
  input  wire        testExit,
  input  wire        powerFaultReportOff,
  input  wire        mainSupplyLowPin,
  input  wire        analogRegFaultPin,
  input  wire        digitalRegFaultPin,
  input  wire        memoryRegFaultPin,
  input  wire        edgeSealBreakPin,
  output wire        supplyFaultAny,
  output wire        dataValid
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [TICK_BITS-1:0] tickValue;
  wire                 oscEn;
  wire                 tickEn;
  wire [4:0]           supplyRaw;
  reg  [4:0]           supplyFlags;
  reg  [4:0]           next_supplyFlags;
  reg  [31:0]          recoveryCount;
  reg                  linkFaultFlag;
  reg                  memThermalLatched;
  reg                  testStateActive;
  reg                  resetOccurredFlag;
  reg                  initInProgressFlag;
  reg  [31:0]          initCount;
  wire                 readSummary;
  wire                 readLink;
  wire                 readSupply;
  wire                 readMemThermal;
  wire [7:0]           summaryValue;
  wire [7:0]           supplyValue;
  wire                 dspFaultSummary;

  // Any bit of a vector set
  function anySet;
    input [7:0] v;
    begin
      anySet = |v;
    end
  endfunction

  // Host read of one address; a write cycle never counts as a read,
  // so a host write cannot disturb any clear-on-read state
  function readHit;
    input       rd;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      readHit = rd & ~wr & (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Prescaler chain: oscillator enable, then divide by 1000
  // The first stage stands in for the primary oscillator: it turns the
  // system clock into one enable per oscillator period. The second
  // stage is the 10-bit prescaler proper.
  srcn_divider #(
    .WIDTH (PRESCALE_BITS),
    .RATIO (OSC_DIV)
  ) u_oscDiv (
    .clk   (clk),
    .rst_b (rst_b),
    .enIn  (1'b1),
    .enOut (oscEn)
  );

  srcn_divider #(
    .WIDTH (PRESCALE_BITS),
    .RATIO (PRESCALE_DIV)
  ) u_prescale (
    .clk   (clk),
    .rst_b (rst_b),
    .enIn  (oscEn),
    .enOut (tickEn)
  );

  // step and wrap
  // Natural 8-bit overflow gives the wrap, so no compare is needed
  // No hold register: the value is a single byte and cannot tear
  // between the read strobe and the registered read data
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickValue <= `SRCN_TICK_RESET;
    end else if (tickEn) begin
      tickValue <= tickValue + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply monitors arrive from analog comparators: synchronise first
  // Limitation: a pin glitch shorter than one clock may be missed;
  // the comparators are expected to stretch their own outputs
  srcn_sync #(
    .WIDTH (5)
  ) u_supplySync (
    .clk   (clk),
    .rst_b (rst_b),
    .dIn   ({mainSupplyLowPin, analogRegFaultPin, digitalRegFaultPin,
             memoryRegFaultPin, edgeSealBreakPin}),
    .dOut  (supplyRaw)
  );

  // shared recovery timer
  // One timer for all bits, so a flapping bit keeps every flag held
  // The counter is wide enough that any recovery length fits
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      recoveryCount <= 32'h0000_0000;
    end else if (anySet({3'b000, supplyRaw})) begin
      recoveryCount <= RECOVERY_CYC;
    end else if (recoveryCount != 32'h0000_0000) begin
      recoveryCount <= recoveryCount - 32'h0000_0001;
    end
  end

  // clear policy
  // Report-off set: flags follow the monitors after recovery.
  // Report-off clear: flags stay until the timer expires and the register is read.
  always @* begin
    next_supplyFlags = supplyFlags | supplyRaw;
    if (recoveryCount == 32'h0000_0000 && !anySet({3'b000, supplyRaw})) begin
      if (powerFaultReportOff) begin
        next_supplyFlags = 5'h00;
      end else if (readSupply) begin
        next_supplyFlags = 5'h00;
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supplyFlags <= 5'h00;
    end else begin
      supplyFlags <= next_supplyFlags;
    end
  end

  // Supply register layout, reserved bits read as zero
  assign supplyValue = {supplyFlags[4], 3'b000, supplyFlags[3:0]};
  assign supplyFaultAny = anySet(supplyValue) & ~initInProgressFlag;

  ////////////////////////////////////////////////////////////////////////
  // Read strobes for clear-on-read registers
  // writes decode to nothing
  assign readSummary    = readHit(regRead, regWrite, regAddr, `SRCN_ADDR_SUMMARY);
  assign readLink       = readHit(regRead, regWrite, regAddr, `SRCN_ADDR_LINK);
  assign readSupply     = readHit(regRead, regWrite, regAddr, `SRCN_ADDR_SUPPLY);
  assign readMemThermal = readHit(regRead, regWrite, regAddr, `SRCN_ADDR_MEMTHERM);

  // link fault, set wins over clear
  // Only SPI transfers compare the echoed output, so in I2C mode
  // a mismatch event cannot raise the flag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkFaultFlag <= 1'b0;
    end else if (spiMode && linkMismatchEvent) begin
      linkFaultFlag <= 1'b1;
    end else if (readLink || (statusSent && statusSentBits[`SRCN_SUM_LINK])) begin
      linkFaultFlag <= 1'b0;
    end
  end

  // Memory/thermal sticky errors cleared by a read of their register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memThermalLatched <= 1'b0;
    end else if (memThermalEvent) begin
      memThermalLatched <= 1'b1;
    end else if (readMemThermal) begin
      memThermalLatched <= 1'b0;
    end
  end

  // test mode state
  // Enter wins over exit so a collision leaves test mode visible
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      testStateActive <= 1'b0;
    end else if (testEnter) begin
      testStateActive <= 1'b1;
    end else if (testExit) begin
      testStateActive <= 1'b0;
    end
  end

  // reset flag, set wins is moot: only reset sets it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetOccurredFlag <= 1'b1;
    end else if (readSummary ||
                 (statusSent && statusSentBits[`SRCN_SUM_RESET])) begin
      resetOccurredFlag <= 1'b0;
    end
  end

  // init flag drops when data valid delay ends
  // The counter stops at the end so it cannot wrap and re-arm
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      initCount          <= 32'h0000_0000;
      initInProgressFlag <= 1'b1;
    end else if (initInProgressFlag) begin
      if (initCount >= DATA_VALID_CYC - 1) begin
        initInProgressFlag <= 1'b0;
      end else begin
        initCount <= initCount + 32'h0000_0001;
      end
    end
  end
  assign dataValid = ~initInProgressFlag;

  ////////////////////////////////////////////////////////////////////////
  // Summary register assembly
  // Bit 6 is reserved and reads zero; the position macros record
  // the layout that the concatenation below follows
  // self-test summary
  assign dspFaultSummary = selftestUnfinished | commonModeFault | selftestFault;

  assign summaryValue = {
    dspFaultSummary,
    1'b0,
    linkFaultFlag,
    memThermalLatched | memWriteActive,
    anySet(supplyValue),
    testStateActive,
    resetOccurredFlag,
    initInProgressFlag
  };

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered data
  // Unmapped addresses read zero; writes never reach storage
  // Read data is registered so the host engine has a full cycle
  // to move it onto its shift register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `SRCN_ADDR_TICK:    regRdData <= tickValue;
        `SRCN_ADDR_SUMMARY: regRdData <= summaryValue;
        `SRCN_ADDR_SUPPLY:  regRdData <= supplyValue;
        default:            regRdData <= 8'h00;
      endcase
    end
  end

endmodule // srcn_status_bank
`default_nettype wire

// [rtl/srcn_sync.v]
// Two flip-flop synchroniser for a vector of level inputs from pins.
// Assumes each bit is a slow level; no multi-bit coherency is kept.
`timescale 1ns/1ps
`default_nettype none
module srcn_sync #(
  parameter integer WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] dIn,
  output reg  [WIDTH-1:0] dOut
);

  reg  [WIDTH-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= {WIDTH{1'b0}};
      dOut   <= {WIDTH{1'b0}};
    end else begin
      stage1 <= dIn;
      dOut   <= stage1;
    end
  end

endmodule // srcn_sync
`default_nettype wire

// [verif/srcn_host_model.sv]
// Host model: reads and writes the bank over its strobe interface.
// Assumes one clock; requests change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module srcn_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output var  logic       regRead,
  output var  logic       regWrite,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData
);
  // Idle bus at time zero
  initial begin
    regRead = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h5a;
    regWrData = 8'ha5;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    // Inverted address so a late sample shows up
    regAddr = ~a;
    @(negedge clk);
    d = regRdData;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWrData = ~v;
  endtask
endmodule // srcn_host_model
`default_nettype wire

// [verif/srcn_status_bank_bench.sv]
// Testbench of the status bank: host reads against event and pin stimulus.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module srcn_status_bank_bench;
  localparam int Rec = 10;
  logic       clk, rst_b, regRead, regWrite, spiMode, memWriteActive;
  logic       powerFaultReportOff, supplyFaultAny, dataValid;
  logic [7:0] regAddr, regWrData, regRdData, statusSentBits, v0;
  logic [4:0] ev, pins;
  logic [2:0] dsp;
  int         nFail, testsRun, cyc;
  srcn_host_model i_host (.clk, .regRdData, .regRead, .regWrite, .regAddr, .regWrData);
  // Short prescale, recovery and init counts keep the run brief
  srcn_status_bank #(.OSC_DIV(2), .PRESCALE_DIV(4), .RECOVERY_CYC(Rec), .DATA_VALID_CYC(40)) i_dut (
    .clk, .rst_b, .regRead, .regWrite, .regAddr, .regWrData, .regRdData,
    .statusSent(ev[4]), .statusSentBits, .linkMismatchEvent(ev[0]), .spiMode,
    .memThermalEvent(ev[1]), .memWriteActive, .testEnter(ev[2]), .testExit(ev[3]),
    .powerFaultReportOff, .supplyFaultAny, .dataValid, .selftestUnfinished(dsp[0]),
    .commonModeFault(dsp[1]), .selftestFault(dsp[2]), .mainSupplyLowPin(pins[4]),
    .analogRegFaultPin(pins[3]), .digitalRegFaultPin(pins[2]),
    .memoryRegFaultPin(pins[1]), .edgeSealBreakPin(pins[0])
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    check($sformatf("register %h", a), exp, d);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    ev[k] = 1'b1;
    @(negedge clk);
    ev[k] = 1'b0;
  endtask
  task automatic doReset();
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task automatic giveVerdict();
    $display("Comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cut a hang short; the tests need some 2700 cycles
  initial begin
    cyc = 0;
    forever @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
        nFail++;
        giveVerdict();
      end
    end
  end
  // Main sequence
  initial begin
    {ev, pins, spiMode, memWriteActive, powerFaultReportOff} = '0;
    statusSentBits = 8'h02;
    dsp = 3'b001;
    nFail = 0;
    testsRun = 0;
    doReset();
    check("data valid", 8'h00, {7'h00, dataValid});
    rdChk(8'h00, 8'h00);
    rdChk(8'h02, 8'h00);
    rdChk(8'h01, 8'h83);
    doReset();
    i_host.wr(8'h01, 8'hff);
    rdChk(8'h01, 8'h83);
    doReset();
    pulse(4);
    rdChk(8'h01, 8'h81);
    for (int k = 0; k < 99 && dataValid !== 1'b1; k++) @(negedge clk);
    check("data valid", 8'h01, {7'h00, dataValid});
    rdChk(8'h01, 8'h80);
    $display("Test reset flags done");
    for (int i = 0; i < 4; i++) begin
      dsp = (i == 3) ? 3'b000 : 3'b001 << i;
      rdChk(8'h01, (i == 3) ? 8'h00 : 8'h80);
    end
    pulse(0);
    rdChk(8'h01, 8'h00);
    spiMode = 1'b1;
    pulse(0);
    rdChk(8'h01, 8'h20);
    rdChk(8'h04, 8'h00);
    rdChk(8'h01, 8'h00);
    pulse(0);
    rdChk(8'h01, 8'h20);
    statusSentBits = 8'h20;
    pulse(4);
    rdChk(8'h01, 8'h00);
    pulse(1);
    rdChk(8'h01, 8'h10);
    rdChk(8'h03, 8'h00);
    rdChk(8'h01, 8'h00);
    memWriteActive = 1'b1;
    rdChk(8'h01, 8'h10);
    memWriteActive = 1'b0;
    rdChk(8'h01, 8'h00);
    pulse(2);
    rdChk(8'h01, 8'h04);
    rdChk(8'h01, 8'h04);
    pulse(3);
    rdChk(8'h01, 8'h00);
    rdChk(8'h07, 8'h00);
    $display("Test summary bits done");
    powerFaultReportOff = 1'b1;
    for (int i = 0; i < 5; i++) begin
      pins = 5'b00001 << i;
      repeat (4) @(negedge clk);
      rdChk(8'h02, (i == 4) ? 8'h80 : 8'h01 << i);
      rdChk(8'h01, 8'h08);
      check("fault any", 8'h01, {7'h00, supplyFaultAny});
      pins = 5'b00000;
      repeat (Rec + 6) @(negedge clk);
      rdChk(8'h02, 8'h00);
      check("fault any", 8'h00, {7'h00, supplyFaultAny});
    end
    powerFaultReportOff = 1'b0;
    pins = 5'b00001;
    repeat (4) @(negedge clk);
    pins = 5'b00000;
    repeat (Rec + 6) @(negedge clk);
    rdChk(8'h02, 8'h01);
    rdChk(8'h02, 8'h00);
    // 2400 cycles between the two taking edges make 300 ticks
    i_host.rd(8'h00, v0);
    i_host.wr(8'h00, 8'hff);
    repeat (2395) @(negedge clk);
    rdChk(8'h00, v0 + 8'd44);
    $display("Test supply and counter done");
    giveVerdict();
  end
endmodule // srcn_status_bank_bench
`default_nettype wire

// [verif/srcn_status_bank_monitor.sv]
// Checker of the status bank ports: read timing, fault and init flags.
// Assumes one clock; bound to the bank at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module srcn_status_bank_monitor #(parameter integer RECOVERY_CYC = 10) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic       selftestUnfinished,
  input wire logic       powerFaultReportOff,
  input wire logic       mainSupplyLowPin,
  input wire logic       analogRegFaultPin,
  input wire logic       digitalRegFaultPin,
  input wire logic       memoryRegFaultPin,
  input wire logic       edgeSealBreakPin,
  input wire logic       supplyFaultAny,
  input wire logic       dataValid
);
  // Bound leaves room for the pin synchroniser
  localparam int RecMax = RECOVERY_CYC + 8;
  wire logic anyPin;
  assign anyPin = mainSupplyLowPin | analogRegFaultPin | digitalRegFaultPin
                | memoryRegFaultPin | edgeSealBreakPin;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // Read answers
  property p_stand; !regRead && !$past(regRead) |=> $stable(regRdData); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_unmap; regRead && regAddr > 8'h04 ##1 !regRead |-> ##[0:1] regRdData == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_dsp; regRead && regAddr == 8'h01 && selftestUnfinished ##1 !regRead |-> ##[0:1] regRdData[7]; endproperty
  a_dsp: assert property (p_dsp) else $error("dsp bit low");
  property p_init; regRead && regAddr == 8'h01 && dataValid ##1 !regRead |-> ##[0:1] !regRdData[0]; endproperty
  a_init: assert property (p_init) else $error("init bit high");
  property p_supbit; regRead && regAddr == 8'h01 && supplyFaultAny ##1 !regRead |-> ##[0:1] regRdData[3]; endproperty
  a_supbit: assert property (p_supbit) else $error("supply bit low");
  // Supply flags against the pins
  property p_rise; $rose(anyPin) && dataValid |-> ##[1:4] supplyFaultAny; endproperty
  a_rise: assert property (p_rise) else $error("fault not flagged");
  property p_hold; supplyFaultAny && anyPin |=> supplyFaultAny; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped early");
  property p_recov; supplyFaultAny && !anyPin && powerFaultReportOff |-> ##[0:RecMax] (!supplyFaultAny || anyPin); endproperty
  a_recov: assert property (p_recov) else $error("fault never cleared");
endmodule // srcn_status_bank_monitor
bind srcn_status_bank srcn_status_bank_monitor #(.RECOVERY_CYC(RECOVERY_CYC)) i_mon (
  .clk, .rst_b, .regRead, .regAddr, .regRdData, .selftestUnfinished,
  .powerFaultReportOff, .mainSupplyLowPin, .analogRegFaultPin, .digitalRegFaultPin,
  .memoryRegFaultPin, .edgeSealBreakPin, .supplyFaultAny, .dataValid
);
`default_nettype wire
